/* File: emsd_mem_model.sv */
// Behavioural external memory on the far side of the expansion bus
`timescale 1ns/1ps
`default_nettype none

module emsd_mem_model (
    // Expansion bus pins
    input wire logic i_clk,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_select_n,
    input wire logic i_output_enable_n,
    input wire logic i_wr_strobe_n,
    // Data back to the device
    output logic [7:0] o_rdata
);
    logic [7:0] mem [16];
    logic [7:0] last = 8'h00;

    always_ff @(posedge i_clk) begin
        if (!i_select_n && !i_wr_strobe_n) begin
            mem[i_addr[3:0]] <= i_wdata;
        end
        last <= o_rdata;
    end

    // Released bus toggles so a stale byte is never mistaken for data
    always_comb begin
        if (!i_select_n && !i_output_enable_n) begin
            o_rdata = mem[i_addr[3:0]];
        end else begin
            o_rdata = ~last;
        end
    end
endmodule

`default_nettype wire

/* File: emsd_pkg.sv */
// Constants, address map and variant codes for the expansion bus decode
package emsd_pkg;

    // ------------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------------
    // Memory variants
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        EMSD_VAR_RAM   = 2'h0,
        EMSD_VAR_ROM8  = 2'h1,
        EMSD_VAR_ROM32 = 2'h2
    } emsd_variant_type;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam logic [15:0] RAM_CODE_TOP = 16'h1B3F;
    localparam logic [15:0] ALIAS_LO = 16'h1B40;
    localparam logic [15:0] ALIAS_HI = 16'h1FFF;
    localparam logic [15:0] REGS_LO = 16'h7B40;
    localparam logic [15:0] REGS_HI = 16'h7FFF;
    localparam logic [15:0] ALIAS_OFFSET = 16'h6000;
    localparam logic [15:0] ISO_LO = 16'h2000;
    localparam logic [15:0] ISO_HI = 16'h27FF;
    localparam logic [15:0] ROM8_DATA_TOP = 16'h07FF;
    localparam logic [15:0] ROM8_CODE_TOP = 16'h1FFF;
    localparam logic [15:0] ROM32_DATA_TOP = 16'h0FFF;
    localparam logic [15:0] ROM32_CODE_TOP = 16'h7FFF;

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    localparam int ISO_OFF_BIT = 0;
    localparam int RD_PIN_BIT = 1;
    localparam int WR_PIN_BIT = 0;

endpackage

/* File: emsd_top.sv */
// Address decode and strobe gating for the external memory expansion bus
// ----------------------------------------------------------------------
// Overview of operation
// - Drive 16-bit address, 8-bit data, read, write and fetch strobes.
// - External-code pin low: low region code and data come from chip RAM.
// - Pin low: fetches at 0x0000-0x1B3F raise no external fetch strobe.
// - Pin low: external code seen only for fetches 0x1B40-0xFFFF.
// - RAM variant: register and buffer block 0x7B40-0x7FFF also answers at 0x1B40-0x1FFF.
// - External moves to internal data regions raise no strobes or selects.
// - Read and write strobes never assert for on-chip addresses.
// - Select is low whenever any gated read, write or fetch strobe is low.
// - External-code pin high (RAM variant only): all fetches external, chip RAM is data only.
// - Isochronous-off setting is bit 0 of the isochronous control reg.
// - Isochronous off: 0x2000-0x27FF is chip data, external outputs quiet.
// - ROM variants: program memory from 0x0000, chip RAM is data only.
// - 8 KB ROM: data 0x0000-0x07FF, code 0x0000-0x1FFF on chip.
// - 32 KB ROM: code 0x0000-0x7FFF, data 0x0000-0x0FFF on chip.
// - ROM variants: data to on-chip ranges gives no read or write strobe.
// - ROM variants: fetches in on-chip program range give no fetch strobe.
// - The core is the only bus master; the address bus is output only.
// - Read and write strobes share two port pins while expansion is used.
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module emsd_top #(
    parameter emsd_pkg::emsd_variant_type VARIANT = emsd_pkg::EMSD_VAR_RAM,
    parameter int ADDR_W = emsd_pkg::ADDR_W,
    parameter int DATA_W = emsd_pkg::DATA_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Core bus, same clock, active high requests
    input wire logic [ADDR_W-1:0] i_core_addr,
    input wire logic i_core_rd,
    input wire logic i_core_wr,
    input wire logic i_core_fetch,
    input wire logic [DATA_W-1:0] i_core_wdata,
    output logic [DATA_W-1:0] o_core_rdata,
    // Configuration
    input wire logic i_external_code_select,
    input wire logic [7:0] i_iso_control_reg,
    input wire logic i_expansion_used,
    input wire logic [1:0] i_port_gpio_out,
    // Internal register block access
    output logic o_reg_block_sel,
    output logic [ADDR_W-1:0] o_reg_block_addr,
    // External memory pins
    output logic [ADDR_W-1:0] o_mem_addr,
    output logic [DATA_W-1:0] o_mem_wdata,
    output logic o_mem_data_oe,
    input wire logic [DATA_W-1:0] i_mem_rdata,
    output logic o_rd_strobe_n,
    output logic o_wr_strobe_n,
    output logic o_code_fetch_strobe_n,
    output logic o_mem_select_n,
    output logic o_mem_output_enable_n
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (ADDR_W != emsd_pkg::ADDR_W) begin : g_bad_addr
        $error("emsd_top: address width must be 16");
    end
    if (DATA_W != emsd_pkg::DATA_W) begin : g_bad_data
        $error("emsd_top: data width must be 8");
    end
    if (VARIANT != emsd_pkg::EMSD_VAR_RAM &&
            VARIANT != emsd_pkg::EMSD_VAR_ROM8 &&
            VARIANT != emsd_pkg::EMSD_VAR_ROM32) begin : g_bad_var
        $error("emsd_top: unknown memory variant");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // The strap may move at any time; decode only sees the second stage.
    logic ea_meta;
    logic ea_sync;
    logic [DATA_W-1:0] rdata_meta;
    logic [DATA_W-1:0] rdata_sync;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ea_meta <= 1'b0;
            ea_sync <= 1'b0;
            rdata_meta <= '0;
            rdata_sync <= '0;
        end else begin
            ea_meta <= i_external_code_select;
            ea_sync <= ea_meta;
            rdata_meta <= i_mem_rdata;
            rdata_sync <= rdata_meta;
        end
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic iso_off;
    logic in_regs;
    logic in_alias;
    logic in_iso;
    logic data_int;
    logic code_int;

    always_comb begin
        iso_off = i_iso_control_reg[emsd_pkg::ISO_OFF_BIT];
        in_regs = i_core_addr >= emsd_pkg::REGS_LO &&
                  i_core_addr <= emsd_pkg::REGS_HI;
        in_alias = i_core_addr >= emsd_pkg::ALIAS_LO &&
                   i_core_addr <= emsd_pkg::ALIAS_HI;
        in_iso = iso_off && i_core_addr >= emsd_pkg::ISO_LO &&
                 i_core_addr <= emsd_pkg::ISO_HI;
        data_int = in_regs || in_iso;
        code_int = 1'b0;
        case (VARIANT)
            emsd_pkg::EMSD_VAR_ROM8: begin
                // Chip RAM is data only here
                data_int = data_int ||
                           i_core_addr <= emsd_pkg::ROM8_DATA_TOP;
                code_int = i_core_addr <= emsd_pkg::ROM8_CODE_TOP;
            end
            emsd_pkg::EMSD_VAR_ROM32: begin
                data_int = data_int ||
                           i_core_addr <= emsd_pkg::ROM32_DATA_TOP;
                code_int = i_core_addr <= emsd_pkg::ROM32_CODE_TOP;
            end
            default: begin
                // Whole low RAM and alias window are on chip
                data_int = data_int || i_core_addr <= emsd_pkg::ALIAS_HI;
                // Strap high sends every fetch outside
                code_int = !ea_sync &&
                           i_core_addr <= emsd_pkg::RAM_CODE_TOP;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Strobe gating and output registers
    // ------------------------------------------------------------------
    // One register stage keeps outputs glitch free; the decode itself adds
    // no wait state, so every access keeps its length.
    logic [ADDR_W-1:0] next_mem_addr;
    logic [DATA_W-1:0] next_mem_wdata;
    logic next_mem_data_oe;
    logic next_rd_n;
    logic next_wr_n;
    logic next_code_n;
    logic next_sel_n;
    logic next_oe_n;
    logic next_reg_sel;
    logic [ADDR_W-1:0] next_reg_addr;
    logic ext_rd;
    logic ext_wr;
    logic ext_fetch;
    logic pin_rd_n;
    logic pin_wr_n;

    always_comb begin
        ext_rd = i_core_rd && !data_int;
        ext_wr = i_core_wr && !data_int;
        ext_fetch = i_core_fetch && !code_int;
        next_mem_addr = i_core_addr;
        next_mem_wdata = i_core_wdata;
        next_mem_data_oe = ext_wr;
        pin_rd_n = !ext_rd;
        pin_wr_n = !ext_wr;
        // Shared port pins fall back to general purpose outputs
        next_rd_n = i_expansion_used ? pin_rd_n :
                    i_port_gpio_out[emsd_pkg::RD_PIN_BIT];
        next_wr_n = i_expansion_used ? pin_wr_n :
                    i_port_gpio_out[emsd_pkg::WR_PIN_BIT];
        next_code_n = !ext_fetch;
        next_sel_n = !(ext_rd || ext_wr || ext_fetch);
        next_oe_n = !(ext_rd || ext_fetch);
        next_reg_sel = (i_core_rd || i_core_wr) && (in_regs ||
                       (VARIANT == emsd_pkg::EMSD_VAR_RAM && in_alias));
        next_reg_addr = in_alias ?
                        ADDR_W'(i_core_addr + emsd_pkg::ALIAS_OFFSET) :
                        i_core_addr;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mem_addr <= '0;
            o_mem_wdata <= '0;
            o_mem_data_oe <= 1'b0;
            o_rd_strobe_n <= 1'b1;
            o_wr_strobe_n <= 1'b1;
            o_code_fetch_strobe_n <= 1'b1;
            o_mem_select_n <= 1'b1;
            o_mem_output_enable_n <= 1'b1;
            o_reg_block_sel <= 1'b0;
            o_reg_block_addr <= '0;
        end else begin
            o_mem_addr <= next_mem_addr;
            o_mem_wdata <= next_mem_wdata;
            o_mem_data_oe <= next_mem_data_oe;
            o_rd_strobe_n <= next_rd_n;
            o_wr_strobe_n <= next_wr_n;
            o_code_fetch_strobe_n <= next_code_n;
            o_mem_select_n <= next_sel_n;
            o_mem_output_enable_n <= next_oe_n;
            o_reg_block_sel <= next_reg_sel;
            o_reg_block_addr <= next_reg_addr;
        end
    end

    assign o_core_rdata = rdata_sync;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    localparam bit IS_RAM = VARIANT == emsd_pkg::EMSD_VAR_RAM;
    localparam bit IS_ROM = VARIANT != emsd_pkg::EMSD_VAR_RAM;

    sequence sq_ext_read;
        i_core_rd && !data_int && !i_core_wr && !i_core_fetch;
    endsequence

    sequence sq_read_strobes;
        !o_mem_select_n && !o_mem_output_enable_n && o_wr_strobe_n;
    endsequence

    sequence sq_ext_write;
        i_core_wr && !data_int && !i_core_rd && !i_core_fetch;
    endsequence

    sequence sq_write_strobes;
        !o_mem_select_n && o_mem_output_enable_n && o_mem_data_oe;
    endsequence

    AST_LOW_FETCH_QUIET: assert property (
        IS_RAM && !ea_sync && i_core_fetch &&
        i_core_addr <= emsd_pkg::RAM_CODE_TOP |=> o_code_fetch_strobe_n)
        else $error("fetch strobe raised for low on-chip code");

    AST_HIGH_FETCH_SEEN: assert property (
        IS_RAM && !ea_sync && i_core_fetch &&
        i_core_addr > emsd_pkg::RAM_CODE_TOP
        |=> !o_code_fetch_strobe_n && !o_mem_output_enable_n)
        else $error("fetch above low code range not external");

    AST_STRAP_HIGH_FETCH: assert property (
        IS_RAM && ea_sync && i_core_fetch |=> !o_code_fetch_strobe_n)
        else $error("strap high fetch did not go external");

    AST_INTERNAL_DATA_QUIET: assert property (
        (i_core_rd || i_core_wr) && !i_core_fetch && data_int
        |=> o_mem_select_n && o_mem_output_enable_n && !o_mem_data_oe)
        else $error("select raised for on-chip data");

    AST_READ_SELECT: assert property (
        sq_ext_read |=> sq_read_strobes)
        else $error("external read lacks select or enable");

    AST_WRITE_NO_OE: assert property (
        sq_ext_write |=> sq_write_strobes)
        else $error("external write drove output enable");

    AST_ISO_WINDOW: assert property (
        i_iso_control_reg[emsd_pkg::ISO_OFF_BIT] && i_core_wr &&
        !i_core_fetch && i_core_addr >= emsd_pkg::ISO_LO &&
        i_core_addr <= emsd_pkg::ISO_HI |=> o_mem_select_n)
        else $error("isochronous window reached external memory");

    AST_ALIAS_MAP: assert property (
        IS_RAM && (i_core_rd || i_core_wr) && in_alias
        |=> o_reg_block_sel &&
            o_reg_block_addr == $past(i_core_addr) + emsd_pkg::ALIAS_OFFSET)
        else $error("alias window not mapped onto register block");

    AST_ROM_CODE_QUIET: assert property (
        IS_ROM && i_core_fetch && code_int |=> o_code_fetch_strobe_n)
        else $error("fetch strobe raised for on-chip program memory");

    AST_STRAP_SYNC: assert property (
        $changed(i_external_code_select) ##1
            $stable(i_external_code_select)[*2]
        |-> ea_sync == i_external_code_select)
        else $error("strap not seen after two stages");

endmodule

`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the expansion bus decode, all three variants
`timescale 1ns/1ps
`default_nettype none

module tb;
    typedef struct packed {
        logic [15:0] addr;
        logic [1:0] kind;
        logic strap;
        logic iso;
        logic [2:0] ext;
    } emsd_row_type;

    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [15:0] i_core_addr = 16'h0000;
    logic i_core_rd = 1'b0;
    logic i_core_wr = 1'b0;
    logic i_core_fetch = 1'b0;
    logic [7:0] i_core_wdata = 8'h00;
    logic i_external_code_select = 1'b0;
    logic [7:0] i_iso_control_reg = 8'h00;
    logic i_expansion_used = 1'b1;
    logic [1:0] i_port_gpio_out = 2'h3;
    wire logic [7:0] mem_rdata;
    wire logic [2:0] rd_n, wr_n, fetch_n, sel_n, oe_n, reg_sel, data_oe;
    wire logic [15:0] mem_addr [3];
    wire logic [15:0] reg_addr [3];
    wire logic [7:0] core_rdata [3];
    wire logic [7:0] mem_wdata [3];
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    // Kind 0 read, 1 write, 2 fetch; ext bit0 RAM, bit1 ROM8, bit2 ROM32
    emsd_row_type rows [0:19] = '{
        '{16'h1B3F, 2'h2, 1'h0, 1'h0, 3'h0}, '{16'h1B40, 2'h2, 1'h0, 1'h0, 3'h1},
        '{16'h2000, 2'h2, 1'h0, 1'h0, 3'h3}, '{16'h7FFF, 2'h2, 1'h0, 1'h0, 3'h3},
        '{16'h8000, 2'h2, 1'h0, 1'h0, 3'h7}, '{16'h0000, 2'h2, 1'h1, 1'h0, 3'h1},
        '{16'h0000, 2'h0, 1'h0, 1'h0, 3'h0}, '{16'h07FF, 2'h0, 1'h1, 1'h0, 3'h0},
        '{16'h0800, 2'h0, 1'h0, 1'h0, 3'h2}, '{16'h0FFF, 2'h1, 1'h0, 1'h0, 3'h2},
        '{16'h1000, 2'h0, 1'h0, 1'h0, 3'h6}, '{16'h1FFF, 2'h1, 1'h0, 1'h0, 3'h6},
        '{16'h2000, 2'h1, 1'h0, 1'h0, 3'h7}, '{16'h2000, 2'h1, 1'h0, 1'h1, 3'h0},
        '{16'h27FF, 2'h0, 1'h0, 1'h1, 3'h0}, '{16'h2800, 2'h0, 1'h0, 1'h1, 3'h7},
        '{16'h7B3F, 2'h1, 1'h0, 1'h0, 3'h7}, '{16'h7B40, 2'h1, 1'h0, 1'h0, 3'h0},
        '{16'h7FFF, 2'h0, 1'h0, 1'h0, 3'h0}, '{16'hFFFF, 2'h0, 1'h0, 1'h0, 3'h7}
    };

    always #5 i_clk = ~i_clk;

    for (genvar g = 0; g < 3; g++) begin : g_var
        emsd_top #(.VARIANT(emsd_pkg::emsd_variant_type'(g))) dut (
            .i_clk(i_clk), .i_rst(i_rst), .i_core_addr(i_core_addr),
            .i_core_rd(i_core_rd), .i_core_wr(i_core_wr),
            .i_core_fetch(i_core_fetch), .i_core_wdata(i_core_wdata),
            .o_core_rdata(core_rdata[g]),
            .i_external_code_select(i_external_code_select),
            .i_iso_control_reg(i_iso_control_reg),
            .i_expansion_used(i_expansion_used),
            .i_port_gpio_out(i_port_gpio_out),
            .o_reg_block_sel(reg_sel[g]), .o_reg_block_addr(reg_addr[g]),
            .o_mem_addr(mem_addr[g]), .o_mem_wdata(mem_wdata[g]),
            .o_mem_data_oe(data_oe[g]), .i_mem_rdata(mem_rdata),
            .o_rd_strobe_n(rd_n[g]), .o_wr_strobe_n(wr_n[g]),
            .o_code_fetch_strobe_n(fetch_n[g]), .o_mem_select_n(sel_n[g]),
            .o_mem_output_enable_n(oe_n[g])
        );
    end

    emsd_mem_model mem (
        .i_clk(i_clk), .i_addr(mem_addr[0]), .i_wdata(mem_wdata[0]),
        .i_select_n(sel_n[0]), .i_output_enable_n(oe_n[0]),
        .i_wr_strobe_n(wr_n[0]), .o_rdata(mem_rdata)
    );

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask

    // One request held for a single cycle; returns once outputs show it
    task automatic do_req(input logic [15:0] a, input logic [1:0] k,
                          input logic [7:0] d);
        i_core_addr = a;
        i_core_rd = (k == 2'h0);
        i_core_wr = (k == 2'h1);
        i_core_fetch = (k == 2'h2);
        i_core_wdata = d;
        @(posedge i_clk);
        #1;
        i_core_rd = 1'b0;
        i_core_wr = 1'b0;
        i_core_fetch = 1'b0;
    endtask

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        logic [2:0] req;
        logic x;
        @(posedge i_clk);
        #1;
        chk("reset_out", 16'h000F, {10'h0, data_oe[0], reg_sel[0], rd_n[0],
            wr_n[0], sel_n[0], oe_n[0]});
        repeat (2) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        // -------------------------------------------------------------
        // Decode table
        // -------------------------------------------------------------
        foreach (rows[i]) begin
            i_external_code_select = rows[i].strap;
            i_iso_control_reg = {7'h00, rows[i].iso};
            repeat (3) @(posedge i_clk);
            #1;
            do_req(rows[i].addr, rows[i].kind, 8'h00);
            req = {rows[i].kind == 2'h2, rows[i].kind == 2'h1,
                   rows[i].kind == 2'h0};
            for (int v = 0; v < 3; v++) begin
                x = rows[i].ext[v];
                chk("strobes", {13'h0, ~(req & {3{x}})},
                    {13'h0, fetch_n[v], wr_n[v], rd_n[v]});
                chk("sel_oe", {14'h0, ~x, ~(x & ~req[1])},
                    {14'h0, sel_n[v], oe_n[v]});
            end
        end
        // -------------------------------------------------------------
        // Write walk, read back through the far side
        // -------------------------------------------------------------
        do_req(16'h8000, 2'h1, 8'hA5);
        chk("wr_walk", 16'h09A5, {4'h0, data_oe[0], wr_n[0], sel_n[0],
            oe_n[0], mem_wdata[0]});
        chk("mem_addr", 16'h8000, mem_addr[0]);
        do_req(16'h8000, 2'h0, 8'h00);
        chk("rd_walk", 16'h0000, {13'h0, rd_n[0], sel_n[0], oe_n[0]});
        // Read byte passes two input stages before the core sees it
        repeat (2) @(posedge i_clk);
        #1;
        chk("rdata", 16'h00A5, {8'h00, core_rdata[0]});
        // Held read gives one strobe cycle per request cycle
        i_core_addr = 16'h9000;
        i_core_rd = 1'b1;
        for (int j = 0; j < 3; j++) begin
            @(posedge i_clk);
            #1;
            if (j == 2) begin
                i_core_rd = 1'b0;
            end
            chk("held_rd", 16'h0000, {15'h0, rd_n[0]});
        end
        @(posedge i_clk);
        #1;
        chk("held_end", 16'h0001, {15'h0, rd_n[0]});
        // -------------------------------------------------------------
        // Register block and its low alias
        // -------------------------------------------------------------
        do_req(16'h7B40, 2'h0, 8'h00);
        chk("reg_hi", 16'h7B40, reg_addr[0]);
        chk("reg_hi_sel", 16'h0001, {15'h0, reg_sel[0]});
        do_req(16'h1B40, 2'h1, 8'h00);
        chk("alias", 16'h7B40, reg_addr[0]);
        chk("alias_sel", 16'h0001, {13'h0, reg_sel});
        // Shared pins fall back to port values, select stays quiet
        i_expansion_used = 1'b0;
        i_port_gpio_out = 2'h1;
        @(posedge i_clk);
        #1;
        @(posedge i_clk);
        #1;
        chk("gpio_pins", 16'h0003, {13'h0, rd_n[0], wr_n[0], sel_n[0]});
        end_sim();
    end
endmodule

`default_nettype wire
